//--- vectored_interrupt_controller.sv
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
// Behaviour
// - All requests merge into one CPU request
// - Up to eight trap sources beside interrupts
// - Seven software-assignable user priority levels
// - Primary table at 0x4, two units apart
// - 126 vectors: 8 traps, 118 interrupts
// - Each vector is a 24-bit address
// - Lower vector position wins natural priority
// - Equal levels resolve by fixed natural order
// - 63 sources and five traps implemented
// - Alternate select bit redirects every vector
// - Alternate entry sits 0x100 above primary
// - Request number is vector minus eight
// - Requests 15, 18, 45 are reserved
// - Reset is no exception, no vector
// - Reset clears registers, execution restarts zero
// - Entry latency fixed for every source
// - Sources set flags, only software clears
// - Three-bit priority field per source
// - Latch winning vector and new level
// - Top CPU level bit read-only
module vectored_interrupt_controller (
   input  wire logic                          clk,
   input  wire logic                          reset,
   input  wire logic [vic_pkg::ADDR_W-1:0]    paddr,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [31:0]                   pwdata,
   input  wire logic [3:0]                    pstrb,
   output logic      [31:0]                   prdata,
   output logic                               pready,
   output logic                               pslverr,
   input  wire logic [vic_pkg::NUM_IRQ-1:0]   irqIn,
   input  wire logic [vic_pkg::NUM_TRAP-1:0]  trapIn,
   input  wire logic                          cpuAck,
   input  wire logic                          cpuReturn,
   input  wire logic [3:0]                    returnLevel,
   output logic                               irqReq,
   output logic      [6:0]                    irqVector,
   output logic      [3:0]                    irqLevel,
   output logic      [23:0]                   vectorAddr
);
   import vic_pkg::*;

   // Byte lanes to bit mask
   function automatic logic [31:0] laneMask(input logic [3:0] s);
      laneMask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction

   // APB phase decode
   wire        wrEn    = psel & penable & pwrite;
   wire        setup   = psel & ~penable;
   wire [31:0] wMask   = laneMask(pstrb);
   wire [1:0]  fWord   = paddr[3:2];
   wire [3:0]  pWord   = paddr[5:2];
   wire        alignOk = paddr[1:0] == 2'h0;

   // Register hits
   wire hitCtrl1 = paddr == OFS_CTRL1;
   wire hitCtrl2 = paddr == OFS_CTRL2;
   wire hitLevel = paddr == OFS_LEVEL;
   wire hitPend  = paddr == OFS_PEND;
   wire hitFlag  = alignOk && paddr[11:4] == OFS_FLAG[11:4];
   wire hitEn    = alignOk && paddr[11:4] == OFS_ENABLE[11:4];
   // Last priority word only partly used
   wire hitPrio  = alignOk && paddr[11:6] == OFS_PRIO[11:6]
                   && pWord < PRIO_WORDS;
   wire mapped   = hitCtrl1 | hitCtrl2 | hitLevel | hitPend
                   | hitFlag | hitEn | hitPrio;

   // Per-source state
   logic [NUM_IRQ-1:0]  flagQ;
   logic [NUM_IRQ-1:0]  enableQ;
   logic [2:0]          prioQ [NUM_IRQ];
   // Trap flags, alternate select, CPU level
   logic [NUM_TRAP-1:0] trapFlagQ;
   logic                altSelQ;
   logic [3:0]          levelQ;
   // Latched winner
   logic                reqQ;
   logic [6:0]          pendVecQ;
   logic [3:0]          pendLvlQ;
   logic [23:0]         vecAddrQ;
   // Bus answer
   logic [31:0]         prdataQ;
   logic                errQ;

   // Per-source flag, enable and priority
   for (genvar s = 0; s < NUM_IRQ; s++) begin : g_src
      localparam logic [1:0] W = 2'(s / 32);
      localparam int         B = s % 32;
      localparam logic [3:0] P = 4'(s / 8);
      localparam int         N = (s % 8) * 4;
      // Write-one-to-clear of this flag
      wire clr   = wrEn && hitFlag && fWord == W && pwdata[B] && pstrb[B / 8];
      wire enWr  = wrEn && hitEn && fWord == W && pstrb[B / 8];
      wire priWr = wrEn && hitPrio && pWord == P && pstrb[N / 8];
      always_ff @(posedge clk or posedge reset) begin
         if (reset) begin
            flagQ[s]   <= 1'b0;
            enableQ[s] <= 1'b0;
            prioQ[s]   <= PRIO_RESET;
         end else begin
            flagQ[s] <= IRQ_IMPL[s] & (irqIn[s] | (flagQ[s] & ~clr));
            if (enWr) begin
               enableQ[s] <= pwdata[B] & IRQ_IMPL[s];
            end
            if (priWr) begin
               prioQ[s] <= pwdata[N +: 3];
            end
         end
      end
   end

   // Read views padded to whole words
   wire [127:0] flagPad = {{(128 - NUM_IRQ){1'b0}}, flagQ};
   wire [127:0] enPad   = {{(128 - NUM_IRQ){1'b0}}, enableQ};
   logic [511:0] prioFlat;
   for (genvar s = 0; s < 128; s++) begin : g_prd
      if (s < NUM_IRQ) begin : g_used
         assign prioFlat[s * 4 +: 4] = {1'b0, prioQ[s]};
      end else begin : g_pad
         assign prioFlat[s * 4 +: 4] = 4'h0;
      end
   end

   // Trap clear mask from control word one
   wire [7:0] trapClr = (wrEn && hitCtrl1) ? (pwdata[7:0] & wMask[7:0]) : 8'h0;

   // Trap flags and alternate select
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         trapFlagQ <= '0;
         altSelQ   <= 1'b0;
      end else begin
         trapFlagQ <= TRAP_IMPL & (trapIn | (trapFlagQ & ~trapClr));
         if (wrEn && hitCtrl2 && pstrb[1]) begin
            altSelQ <= pwdata[ALT_BIT];
         end
      end
   end

   // CPU level: entry beats return beats software
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         levelQ <= LEVEL_RESET;
      end else if (cpuAck && reqQ) begin
         levelQ <= pendLvlQ;
      end else if (cpuReturn) begin
         levelQ <= returnLevel;
      end else if (wrEn && hitLevel && pstrb[0]) begin
         // software reaches low three bits only
         levelQ[2:0] <= pwdata[2:0];
      end
   end

   // Candidate table in vector order
   logic [NUM_VEC-1:0] vecAct;
   logic [3:0]         vecLvl [NUM_VEC];
   // eight traps ahead of user vectors
   for (genvar v = 0; v < NUM_VEC; v++) begin : g_vec
      if (v < NUM_TRAP) begin : g_trap
         assign vecAct[v] = trapFlagQ[v];
         assign vecLvl[v] = 4'(TRAP_TOP - v);
      end else begin : g_user
         // request number is vector minus eight
         assign vecAct[v] = flagQ[v - NUM_TRAP] & enableQ[v - NUM_TRAP];
         assign vecLvl[v] = {1'b0, prioQ[v - NUM_TRAP]};
      end
   end

   // Arbiter over all vectors
   logic [3:0] bestLvl;
   logic [6:0] bestVec;
   always_comb begin
      bestLvl = 4'h0;
      bestVec = 7'h0;
      // scan downward so lower vectors win
      for (int v = NUM_VEC - 1; v >= 0; v--) begin
         if (vecAct[v] && vecLvl[v] > levelQ && vecLvl[v] >= bestLvl) begin
            bestLvl = vecLvl[v];
            bestVec = 7'(v);
         end
      end
   end
   // Level zero can never exceed the CPU level
   wire found = bestLvl != 4'h0;

   wire [23:0] altAdd   = altSelQ ? ALT_OFFSET : 24'h0;
   wire [23:0] vecAddrD = PRIMARY_BASE + {16'h0, bestVec, 1'b0} + altAdd;

   // Winner latch, one cycle for every source
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         reqQ     <= 1'b0;
         pendVecQ <= 7'h0;
         pendLvlQ <= 4'h0;
         vecAddrQ <= 24'h0;
      end else begin
         reqQ     <= found;
         pendVecQ <= bestVec;
         pendLvlQ <= bestLvl;
         vecAddrQ <= vecAddrD;
      end
   end

   assign irqReq     = reqQ;
   assign irqVector  = pendVecQ;
   assign irqLevel   = pendLvlQ;
   assign vectorAddr = vecAddrQ;

   // Read mux; bus state is read at setup
   wire [31:0] rdData =
      hitCtrl1 ? {24'h0, trapFlagQ} :
      hitCtrl2 ? {16'h0, altSelQ, 15'h0} :
      hitLevel ? {28'h0, levelQ} :
      hitPend  ? {20'h0, pendLvlQ, 1'b0, pendVecQ} :
      hitFlag  ? flagPad[fWord * 32 +: 32] :
      hitEn    ? enPad[fWord * 32 +: 32] :
      hitPrio  ? prioFlat[pWord * 32 +: 32] : 32'h0;

   // Capture answer in setup so access has no wait
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prdataQ <= 32'h0;
         errQ    <= 1'b0;
      end else if (setup) begin
         prdataQ <= rdData;
         errQ    <= ~mapped;
      end
   end

   // Always ready; error only in access phase
   assign pready  = 1'b1;
   assign pslverr = psel & penable & errQ;
   assign prdata  = prdataQ;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   level_gate_a : assert property (
      reqQ |-> pendLvlQ > $past(levelQ) && pendLvlQ != 4'h0)
      else $error("request without higher level");

   fixed_lat_a : assert property (
      reqQ == $past(found) && pendVecQ == $past(bestVec))
      else $error("winner latency not one cycle");

   alt_addr_a : assert property (
      reqQ |-> vectorAddr == PRIMARY_BASE + {16'h0, pendVecQ, 1'b0}
               + ($past(altSelQ) ? ALT_OFFSET : 24'h0))
      else $error("vector address wrong");

   trap_win_a : assert property (
      $past(|trapFlagQ && levelQ < 4'h8) |-> reqQ && pendVecQ < 7'd8)
      else $error("trap lost to user source");

   tie_order_a : assert property (
      $past(vecAct[8] && vecLvl[8] > levelQ && vecLvl[8] == bestLvl)
      |-> pendVecQ <= 7'd8)
      else $error("tie not by natural order");

   flag_set_a : assert property (
      irqIn[0] |=> flagQ[0] [*1] ##0 flagQ[0])
      else $error("flag not set by source");

   flag_hold_a : assert property (
      flagQ[0] && !(wrEn && hitFlag && fWord == 2'h0 && pwdata[0] && pstrb[0])
      |=> flagQ[0])
      else $error("flag lost without clear");

   top_bit_a : assert property (
      $rose(levelQ[3]) |-> $past(cpuAck && reqQ || cpuReturn))
      else $error("top level bit set by software");

   rsvd_slot_a : assert property (
      !flagQ[15] && !flagQ[18] && !flagQ[45])
      else $error("reserved slot flagged");

endmodule // vectored_interrupt_controller

//--- vic_pkg.sv
package vic_pkg;
   // Source counts
   localparam int NUM_IRQ  = 118;
   localparam int NUM_TRAP = 8;
   localparam int NUM_VEC  = 126;
   // Trap levels sit above every user level
   localparam int TRAP_TOP = 15;
   // Vector address map
   localparam logic [23:0] PRIMARY_BASE = 24'h000004;
   localparam logic [23:0] ALT_OFFSET   = 24'h000100;
   // Request slots with nothing behind them
   localparam logic [117:0] IRQ_RSVD = (118'h1 << 15) | (118'h1 << 18)
      | (118'h1 << 45) | (118'h3 << 57) | (118'h7 << 62) | (118'h1 << 67)
      | ({118{1'b1}} << 72);
   localparam logic [117:0] IRQ_IMPL  = ~IRQ_RSVD;
   // Oscillator, address, stack, math, DMA traps
   localparam logic [7:0]   TRAP_IMPL = 8'h3e;
   // Register byte offsets
   localparam int ADDR_W = 12;
   localparam logic [11:0] OFS_CTRL1  = 12'h000;
   localparam logic [11:0] OFS_CTRL2  = 12'h004;
   localparam logic [11:0] OFS_LEVEL  = 12'h008;
   localparam logic [11:0] OFS_PEND   = 12'h00c;
   localparam logic [11:0] OFS_FLAG   = 12'h010;
   localparam logic [11:0] OFS_ENABLE = 12'h020;
   localparam logic [11:0] OFS_PRIO   = 12'h040;
   localparam logic [3:0]  PRIO_WORDS = 4'hf;
   // Field positions
   localparam int ALT_BIT      = 15;
   localparam int PEND_LVL_LSB = 8;
   // Reset values
   localparam logic [3:0] LEVEL_RESET = 4'h0;
   localparam logic [2:0] PRIO_RESET  = 3'h0;
endpackage

//--- core_model.sv
`timescale 1ns/1ps
// Core side: takes each request once, returns on command
module core_model (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       irqReq,
   input  wire logic       ackOn,
   input  wire logic       retGo,
   output logic            cpuAck,
   output logic            cpuReturn,
   output logic [3:0]      returnLevel
);
   logic holdQ;  // Blocks a second ack on the stale request cycle
   // Returns always drop back to the lowest level
   assign returnLevel = 4'h0;
   // Ack pulse, then skip two cycles because the request lingers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cpuAck    <= 1'b0;
         cpuReturn <= 1'b0;
         holdQ     <= 1'b0;
      end else begin
         cpuAck    <= ackOn && irqReq && !cpuAck && !holdQ;
         cpuReturn <= retGo;
         holdQ     <= cpuAck;
      end
   end
endmodule // core_model

//--- test_vectored_interrupt_controller.sv
`timescale 1ns/1ps
module test_vectored_interrupt_controller;
   import vic_pkg::*;
   logic                clk, reset, psel, penable, pwrite, pready, pslverr, err, alt;
   logic                cpuAck, cpuReturn, irqReq, ackOn, retGo;
   logic [11:0]         paddr;
   logic [31:0]         pwdata, prdata, rd;
   logic [3:0]          pstrb, returnLevel, irqLevel;
   logic [2:0]          p;
   logic [NUM_IRQ-1:0]  irqIn;
   logic [NUM_TRAP-1:0] trapIn;
   logic [6:0]          irqVector;
   logic [23:0]         vectorAddr;
   int                  errors, tests_run, r;
   vectored_interrupt_controller vectored_interrupt_controller_i (.clk(clk), .reset(reset),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irqIn(irqIn),
      .trapIn(trapIn), .cpuAck(cpuAck), .cpuReturn(cpuReturn), .returnLevel(returnLevel),
      .irqReq(irqReq), .irqVector(irqVector), .irqLevel(irqLevel), .vectorAddr(vectorAddr));
   core_model core_model_i (.clk(clk), .reset(reset), .irqReq(irqReq), .ackOn(ackOn),
      .retGo(retGo), .cpuAck(cpuAck), .cpuReturn(cpuReturn), .returnLevel(returnLevel));
   // Free-running system clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic end_of_test();
      if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; extra idle edge keeps psel from being set twice in a step
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         errors++;
         end_of_test();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   // Sampled on falling edges where outputs are settled, then realign
   task automatic waitReq(input logic v);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (irqReq !== v && n < 10);
      if (irqReq !== v) begin
         errors++;
         end_of_test();
      end
      @(posedge clk);
   endtask
   // Give one source a level, enable it alone in its enable word and pulse its input
   task automatic arm(input int s, input logic [2:0] lv);
      apb(1'b1, OFS_PRIO + 12'((s / 8) * 4), 32'(lv) << ((s % 8) * 4));
      apb(1'b1, OFS_ENABLE + 12'((s / 32) * 4), 32'h1 << (s % 32));
      irqIn[s] <= 1'b1;
      @(posedge clk);
      irqIn <= '0;
   endtask
   function automatic logic [23:0] va(input int vec, input logic a);
      return PRIMARY_BASE + 24'(2 * vec) + (a ? ALT_OFFSET : 24'h0);
   endfunction
   initial begin
      {psel, penable, pwrite, ackOn, retGo, err} = '0;
      paddr = '0; pwdata = '0; pstrb = 4'hf; irqIn = '0; trapIn = '0;
      errors = 0; tests_run = 0;
      reset = 1'b1;
      repeat (4) @(posedge clk);
      reset <= 1'b0;
      chk(irqReq, 0);
      chk(pready, 1);
      void'($urandom(92597));
      // Random sources, levels and table choice
      for (int k = 0; k < 6; k++) begin
         r = $urandom % 72;
         if (IRQ_RSVD[r]) r = 0;
         p = 3'($urandom % 7 + 1);
         alt = 1'($urandom % 2);
         apb(1'b1, OFS_CTRL2, 32'(alt) << ALT_BIT);
         arm(r, p);
         waitReq(1'b1);
         chk(irqVector, 32'(r + 8));
         chk(irqLevel, 32'(p));
         chk(vectorAddr, va(r + 8, alt));
         apb(1'b0, OFS_PEND, 0);
         chk(rd, {20'h0, 1'b0, p, 1'b0, 7'(r + 8)});
         ackOn <= 1'b1;
         waitReq(1'b0);
         ackOn <= 1'b0;
         apb(1'b0, OFS_LEVEL, 0);
         chk(rd, 32'(p));
         apb(1'b1, OFS_FLAG + 12'((r / 32) * 4), 32'h1 << (r % 32));
         retGo <= 1'b1;
         @(posedge clk);
         retGo <= 1'b0;
         repeat (2) @(posedge clk);
         apb(1'b0, OFS_LEVEL, 0);
         chk(rd, 0);
      end
      // equal levels settle by natural order
      apb(1'b1, OFS_PRIO, 32'h44);
      apb(1'b1, OFS_ENABLE, 32'h3);
      irqIn[1:0] <= 2'b11;
      @(posedge clk);
      irqIn <= '0;
      waitReq(1'b1);
      chk(irqVector, 8);
      apb(1'b1, OFS_PRIO, 32'h54);
      waitReq(1'b1);
      chk(irqVector, 9);
      // a trap beats a level-five user source
      trapIn[1] <= 1'b1;
      @(posedge clk);
      trapIn <= '0;
      // Winner is latched one edge after the flag; the old request still stands
      @(posedge clk);
      waitReq(1'b1);
      chk(irqVector, 1);
      chk(irqLevel, 32'(TRAP_TOP - 1));
      // Core takes the trap, so the top level bit comes from entry
      ackOn <= 1'b1;
      waitReq(1'b0);
      ackOn <= 1'b0;
      apb(1'b0, OFS_LEVEL, 0);
      chk(rd, 32'(TRAP_TOP - 1));
      // Software cannot clear the top bit
      apb(1'b1, OFS_LEVEL, 32'h0);
      apb(1'b0, OFS_LEVEL, 0);
      chk(rd, 8);
      apb(1'b1, OFS_CTRL1, 32'h2);
      apb(1'b1, OFS_FLAG, 32'h3);
      retGo <= 1'b1;
      @(posedge clk);
      retGo <= 1'b0;
      // reserved slot and level zero stay silent
      arm(45, 3'h7);
      arm(3, 3'h0);
      // Traps zero, six and seven have nothing behind them
      trapIn <= 8'hc1;
      @(posedge clk);
      trapIn <= '0;
      repeat (4) @(posedge clk);
      chk(irqReq, 0);
      apb(1'b0, OFS_CTRL1, 0);
      chk(rd, 0);
      apb(1'b1, OFS_LEVEL, 32'hf);
      apb(1'b0, OFS_LEVEL, 0);
      chk(rd, 7);
      chk(err, 0);
      apb(1'b1, OFS_LEVEL, 32'h5);
      arm(4, 3'h5);
      repeat (4) @(posedge clk);
      chk(irqReq, 0);
      apb(1'b1, OFS_LEVEL, 32'h0);
      waitReq(1'b1);
      chk(irqVector, 12);
      // Reset in mid-run drops the request and clears all state
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      chk(irqReq, 0);
      chk(vectorAddr, 0);
      apb(1'b0, OFS_CTRL2, 0);
      chk(rd, 0);
      apb(1'b0, OFS_FLAG, 0);
      chk(rd, 0);
      apb(1'b0, 12'hffc, 0);
      chk(err, 1);
      end_of_test();
   end
endmodule // test_vectored_interrupt_controller
